// *** pfpt_asserts.sv ***
// Checker on the register block ports.
// Assumes bound to every register block instance.
`timescale 1ns/1ns
module pfpt_asserts (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] cmdWrData,
  input wire logic [7:0] cmdRdData,
  input wire logic cmdRdValid,
  input wire logic [3:0] overcurrentFault,
  input wire logic [3:0] powerCutFault,
  input wire logic [1:0] summedPowerCutFault,
  input wire logic [3:0] channelOff,
  input wire logic [1:0] summedPowerCutActive,
  input wire logic [1:0] disconnectThresholdSelect
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence polWr; cmdValid && cmdWrite && cmdCode == 8'h2d; endsequence
  sequence rdReq; cmdValid && !cmdWrite; endsequence
  AST_RD_ANS: assert property (rdReq |=> cmdRdValid) else $error("no read answer");
  AST_NO_ANS: assert property (!(cmdValid && !cmdWrite) |=> !cmdRdValid) else $error("stray");
  AST_RD_HOLD: assert property (!cmdRdValid |-> $stable(cmdRdData)) else $error("data moved");
  AST_UNMAP: assert property (rdReq ##0 cmdCode == 8'h2e |=> cmdRdData == 8'h00) else $error("um");
  AST_SUM: assert property (polWr |=> ##1 summedPowerCutActive == $past(cmdWrData[3:2], 2))
    else $error("summed enable");
  AST_DCT: assert property (polWr |=> ##1 disconnectThresholdSelect == $past(cmdWrData[1:0], 2))
    else $error("threshold");
  // Own faults always switch the channel, whatever the policy
  AST_OWN_OFF: assert property (!$past(srst) |-> (channelOff & $past(overcurrentFault | powerCutFault))
    == $past(overcurrentFault | powerCutFault)) else $error("own off");
  AST_QUIET: assert property ({overcurrentFault, powerCutFault, summedPowerCutFault} == 10'h000
    |=> channelOff == 4'h0) else $error("off without fault");
endmodule // pfpt_asserts
bind pfpt_fault_policy_regs pfpt_asserts chk (.*);

// *** pfpt_fault_policy_regs.sv ***
// Fault policy and die temperature registers of a four-channel pair group.
// Assumes fault inputs are clk_sys logic; commands arrive one per cycle.
`timescale 1ns/1ns
module pfpt_fault_policy_regs
  import pfpt_pkg::*;
#(
  parameter int REFRESH_CYCLES = PFPT_TEMP_REFRESH_CYCLES
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] cmdWrData,
  output logic [7:0] cmdRdData,
  output logic cmdRdValid,
  input wire logic [7:0] convCode,
  input wire logic autoMode,
  input wire logic [1:0] singleSigTurnOn,
  input wire logic [3:0] overcurrentFault,
  input wire logic [3:0] powerCutFault,
  input wire logic [1:0] summedPowerCutFault,
  output logic [3:0] channelOff,
  output logic [1:0] summedPowerCutActive,
  output logic [1:0] disconnectThresholdSelect
);
  pfpt_temp_if temp ();
  logic [7:0] policy;
  logic [1:0] overcurrentBothChannelOff;
  logic [1:0] powerCutBothChannelOff;
  logic [1:0] summedPowerCutEnable;
  logic [1:0] autoSet;
  logic [3:0] next_channelOff;

  pfpt_temp_sampler #(
    .REFRESH_CYCLES(REFRESH_CYCLES)
  ) u_sampler (
    .clk_sys(clk_sys),
    .srst(srst),
    .convCode(convCode),
    .temp(temp)
  );

  assign overcurrentBothChannelOff = policy[PFPT_OVERCURRENT_LSB +: 2];
  assign powerCutBothChannelOff = policy[PFPT_POWER_CUT_LSB +: 2];
  assign summedPowerCutEnable = policy[PFPT_SUMMED_PCUT_LSB +: 2];
  assign autoSet = autoMode ? singleSigTurnOn : 2'b00;

  // Host write, then the automatic set on top so a same-cycle turn-on is not lost
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      policy <= PFPT_POLICY_RESET;
    end else begin
      if (cmdValid && cmdWrite && cmdCode == PFPT_CMD_POLICY) begin
        policy <= cmdWrData;
      end
      for (int p = 0; p < 2; p++) begin
        if (autoSet[p]) begin
          policy[PFPT_OVERCURRENT_LSB + p] <= 1'b1;
          policy[PFPT_POWER_CUT_LSB + p] <= 1'b1;
        end
      end
    end
  end

  // Reads answer one cycle later; writes to the temperature byte are ignored
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmdRdData <= PFPT_UNMAPPED_READ;
      cmdRdValid <= 1'b0;
    end else begin
      cmdRdValid <= cmdValid && !cmdWrite;
      if (cmdValid && !cmdWrite) begin
        case (cmdCode)
          PFPT_CMD_TEMP: cmdRdData <= temp.code;
          PFPT_CMD_POLICY: cmdRdData <= policy;
          default: cmdRdData <= PFPT_UNMAPPED_READ;
        endcase
      end
    end
  end

  // Per port: channels 2p and 2p+1 form one 4-pair port
  always_comb begin
    next_channelOff = 4'h0;
    for (int p = 0; p < 2; p++) begin
      logic ocAny;
      logic pcAny;
      ocAny = overcurrentFault[2*p] | overcurrentFault[2*p+1];
      pcAny = powerCutFault[2*p] | powerCutFault[2*p+1];
      // Overcurrent acts whatever the summed enable says
      if (overcurrentBothChannelOff[p]) begin
        next_channelOff[2*p +: 2] = {2{ocAny}};
      end else begin
        next_channelOff[2*p +: 2] = overcurrentFault[2*p +: 2];
      end
      if (powerCutBothChannelOff[p]) begin
        next_channelOff[2*p +: 2] = next_channelOff[2*p +: 2] | {2{pcAny}};
      end else begin
        next_channelOff[2*p +: 2] = next_channelOff[2*p +: 2] | powerCutFault[2*p +: 2];
      end
      if (summedPowerCutEnable[p] && summedPowerCutFault[p]) begin
        next_channelOff[2*p +: 2] = 2'b11;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      channelOff <= 4'h0;
      summedPowerCutActive <= 2'b00;
      disconnectThresholdSelect <= 2'b00;
    end else begin
      channelOff <= next_channelOff;
      summedPowerCutActive <= summedPowerCutEnable;
      disconnectThresholdSelect <= policy[PFPT_DISCONNECT_LSB +: 2];
    end
  end
endmodule // pfpt_fault_policy_regs

// *** pfpt_host.sv ***
// Host model issuing single byte commands.
// Assumes one idle cycle between commands.
`timescale 1ns/1ns
module pfpt_host (
  input wire logic clk_sys,
  input wire logic [7:0] cmdRdData,
  output logic cmdValid,
  output logic cmdWrite,
  output logic [7:0] cmdCode,
  output logic [7:0] cmdWrData
);
  initial {cmdValid, cmdWrite, cmdCode, cmdWrData} = '0;
  task automatic xfer(input logic w, input logic [7:0] c, d, output logic [7:0] q);
    @(posedge clk_sys);
    {cmdValid, cmdWrite, cmdCode, cmdWrData} <= {1'b1, w, c, d};
    @(posedge clk_sys);
    cmdValid <= 1'b0;
    cmdWrData <= ~d;
    #1 q = cmdRdData;
  endtask
endmodule // pfpt_host

// *** pfpt_pkg.sv ***
// Package for the fault policy and die temperature register pair.
// Assumes a 100 MHz system clock and command-coded register access.
package pfpt_pkg;
  localparam logic [7:0] PFPT_CMD_TEMP = 8'h2c;
  localparam logic [7:0] PFPT_CMD_POLICY = 8'h2d;
  localparam logic [7:0] PFPT_TEMP_RESET = 8'h00;
  localparam logic [7:0] PFPT_POLICY_RESET = 8'h00;
  localparam logic [7:0] PFPT_UNMAPPED_READ = 8'h00;
  // Policy field positions; upper bit of each pair serves channels 3-4
  localparam int PFPT_OVERCURRENT_LSB = 6;
  localparam int PFPT_POWER_CUT_LSB = 4;
  localparam int PFPT_SUMMED_PCUT_LSB = 2;
  localparam int PFPT_DISCONNECT_LSB = 0;
  // Temperature = offset + code * step, in millidegrees Celsius
  localparam int PFPT_TEMP_OFFSET_MDEGC = -20000;
  localparam int PFPT_TEMP_STEP_MDEGC = 652;
  localparam int PFPT_TEMP_FULL_SCALE_MDEGC = 146200;
  // Disconnect thresholds in microamps, typical
  localparam int PFPT_DISCONNECT_LOW_UA = 4500;
  localparam int PFPT_DISCONNECT_HIGH_UA = 6500;
  localparam int PFPT_CLK_KHZ = 100000;
  localparam int PFPT_TEMP_REFRESH_MS = 1000;
  localparam int PFPT_TEMP_REFRESH_CYCLES = PFPT_TEMP_REFRESH_MS * PFPT_CLK_KHZ;
endpackage

// *** pfpt_temp_if.sv ***
// Carrier between the temperature sampler and the register bank.
// Assumes both ends share clk_sys.
`timescale 1ns/1ns
interface pfpt_temp_if;
  logic [7:0] code;
  logic refreshed;
  modport producer (output code, output refreshed);
  modport consumer (input code, input refreshed);
endinterface

// *** pfpt_temp_sampler.sv ***
// Periodic die temperature sampler with whole-byte capture.
// Assumes the converter result is stable logic on clk_sys.
`timescale 1ns/1ns
module pfpt_temp_sampler
  import pfpt_pkg::*;
#(
  parameter int REFRESH_CYCLES = PFPT_TEMP_REFRESH_CYCLES
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] convCode,
  pfpt_temp_if.producer temp
);
  logic [31:0] tickCount;
  logic tick;

  always_ff @(posedge clk_sys) begin
    if (srst || tick) begin
      tickCount <= 32'h0;
    end else begin
      tickCount <= tickCount + 32'h1;
    end
  end

  assign tick = (tickCount == 32'(REFRESH_CYCLES - 1));

  // One register load, so a read never mixes two conversions
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      temp.code <= PFPT_TEMP_RESET;
      temp.refreshed <= 1'b0;
    end else begin
      temp.refreshed <= tick;
      if (tick) begin
        temp.code <= convCode;
      end
    end
  end
endmodule // pfpt_temp_sampler

// *** pse_fault_policy_temp_regs_bench.sv ***
// Bench for fault policy and temperature registers.
// Assumes a 20 cycle refresh period.
`timescale 1ns/1ns
module pse_fault_policy_temp_regs_bench;
  typedef struct packed {logic [7:0] pol; logic [3:0] oc, pc; logic [1:0] sum; logic [3:0] off;} pfpt_row_s;
  pfpt_row_s rows [7] = '{'{8'h40, 4'h1, 4'h0, 2'h0, 4'h3}, '{8'h00, 4'h1, 4'h0, 2'h0, 4'h1},
    '{8'h20, 4'h0, 4'h4, 2'h0, 4'hc}, '{8'h00, 4'h0, 4'h4, 2'h0, 4'h4},
    '{8'h0d, 4'h0, 4'h0, 2'h1, 4'h3}, '{8'h02, 4'h2, 4'h0, 2'h2, 4'h2},
    '{8'h80, 4'h8, 4'h0, 2'h0, 4'hc}};
  logic clk_sys, srst, cmdValid, cmdWrite, cmdRdValid, autoMode;
  logic [7:0] cmdCode, cmdWrData, cmdRdData, convCode, q;
  logic [3:0] overcurrentFault, powerCutFault, channelOff;
  logic [1:0] singleSigTurnOn, summedPowerCutFault, summedPowerCutActive, disconnectThresholdSelect;
  int err_total, checks;
  pfpt_fault_policy_regs #(.REFRESH_CYCLES(20)) DUT (.*);
  pfpt_host h (.*);
  task automatic chk(input string n, input logic [7:0] e, s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {srst, convCode, autoMode, singleSigTurnOn} = 12'h800;
    {overcurrentFault, powerCutFault, summedPowerCutFault} = '0;
    repeat (10) @(posedge clk_sys);
    srst <= 0;
    h.xfer(0, 8'h2d, 0, q);
    chk("policy reset", 8'h00, q);
    h.xfer(0, 8'h2c, 0, q);
    chk("temp reset", 8'h00, q);
    foreach (rows[i]) begin
      h.xfer(1, 8'h2d, rows[i].pol, q);
      @(posedge clk_sys);
      {overcurrentFault, powerCutFault, summedPowerCutFault} <= {rows[i].oc, rows[i].pc, rows[i].sum};
      repeat (2) @(posedge clk_sys);
      #1 chk("channelOff", {4'h0, rows[i].off}, {4'h0, channelOff});
      chk("outs", {4'h0, rows[i].pol[3:0]}, {4'h0, summedPowerCutActive, disconnectThresholdSelect});
      h.xfer(0, 8'h2d, 0, q);
      chk("policy", rows[i].pol, q);
    end
    $display("table done");
    @(posedge clk_sys);
    convCode <= 8'h5a;
    repeat (25) @(posedge clk_sys);
    h.xfer(1, 8'h2c, 8'hff, q);
    h.xfer(0, 8'h2c, 0, q);
    chk("temp", 8'h5a, q);
    h.xfer(0, 8'h2e, 0, q);
    chk("unmapped", 8'h00, q);
    h.xfer(1, 8'h2d, 8'h00, q);
    autoMode <= 1;
    singleSigTurnOn <= 2'b10;
    @(posedge clk_sys);
    singleSigTurnOn <= 2'b00;
    h.xfer(0, 8'h2d, 0, q);
    chk("auto set", 8'ha0, q);
    $display("temp and auto done");
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    report_and_stop();
  end
endmodule // pse_fault_policy_temp_regs_bench
